/* src/mtbpm_defines.svh */
`ifndef MTBPM_DEFINES_SVH
`define MTBPM_DEFINES_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MTBPM_OFS_POS    12'h000
`define MTBPM_OFS_MASTER 12'h004
`define MTBPM_OFS_FLOW   12'h008
`define MTBPM_OFS_BASE   12'h00C
// ----------------------------------------
// Memory placement
// ----------------------------------------
`define MTBPM_RAM_START  32'h2000_0000
`define MTBPM_RAM_SIZE   32'h0000_4000
`define MTBPM_BASE_VAL   (`MTBPM_RAM_START - (`MTBPM_RAM_SIZE >> 2))
// ----------------------------------------
// Field positions and limits
// ----------------------------------------
`define MTBPM_M_EN       31
`define MTBPM_M_HALT     9
`define MTBPM_M_RPRIV    8
`define MTBPM_M_WPRIV    7
`define MTBPM_M_STOPEN   6
`define MTBPM_M_STARTEN  5
`define MTBPM_F_AUTOHALT 1
`define MTBPM_F_AUTOSTOP 0
`define MTBPM_POS_WRAP   2
`define MTBPM_MASK_MAX   5'h0B
`define MTBPM_RST        1'b0
`define MTBPM_FIFO_DEPTH 8
`define MTBPM_PKT_W      64
`endif

/* src/mtbpm_pkg.sv */
`default_nettype none
package mtbpm_pkg;
  // Packet slot pointer, address bits 14:3
  typedef logic [11:0] mtbpm_ptr_t;
  // Packet drain word select
  typedef enum logic {
    MTBPM_ST_FIRST  = 1'b0,
    MTBPM_ST_SECOND = 1'b1
  } mtbpm_state_t;
endpackage
`default_nettype wire

/* src/mtbpm_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mtbpm_defines.svh"

// ----------------------------------------
// Packet FIFO
// ----------------------------------------
module mtbpm_fifo #(
  parameter int W = `MTBPM_PKT_W,
  parameter int D = `MTBPM_FIFO_DEPTH
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wr_idx, rd_idx;
  // Extra index bit tells full from empty
  assign out_valid = wr_idx != rd_idx;
  assign in_ready  = (wr_idx[AW-1:0] != rd_idx[AW-1:0]) || (wr_idx[AW] == rd_idx[AW]);
  assign out_data  = mem[rd_idx[AW-1:0]];
  always_ff @(posedge core_clk) begin
    if (in_valid && in_ready) mem[wr_idx[AW-1:0]] <= in_data;
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_idx <= '0;
      rd_idx <= '0;
    end else begin
      if (in_valid && in_ready) wr_idx <= wr_idx + 1'b1;
      if (out_valid && out_ready) rd_idx <= rd_idx + 1'b1;
    end
  end
endmodule // mtbpm_fifo

// Overview of operation
// - Position register takes software writes and hardware updates per recorded packet.
// - Base register reads RAM start minus a quarter of RAM size.
// - Pointer holds address bits 14:3 of next free slot, auto-increments.
// - Position bits 31:15 read zero; only pointer bits 14:3 exist.
// - Wrap flag sets when pointer wraps at the mask boundary.
// - Reserved position bits 1:0 and master bits 30:10 read zero.
// - Master register takes writes; enable and halt also set by hardware.
// - While enabled each packet goes to pointer slot, then pointer advances.
// - Watermark match with auto-stop clears enable.
// - Start input with start enable sets enable.
// - Stop input with stop enable clears enable.
// - After watermark stop, start input is blocked until pointer or watermark change.
// - Halt bit drives halt output, gated by invasive debug enable.
// - RAM privilege bit makes user RAM accesses read zero, writes ignored.
// - Write privilege bit drops user writes to control registers.
// - A packet already in flight is finished when tracing stops.
// - Mask gives circular buffer of 2^(mask+4) bytes, a mask above 11 acting as 11; wrap clears low bits.
// - Pointer matching watermark triggers auto-halt and auto-stop actions.
module mtbpm_top (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        hsel_reg,
  input  wire logic        hsel_ram,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [3:0]  hprot,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [30:0] iaex,
  input  wire logic        iaexen,
  input  wire logic        iaeseq,
  input  wire logic        trace_start_input,
  input  wire logic        trace_stop_input,
  input  wire logic        invasive_debug_enable,
  output logic             core_halt_request_out,
  output logic             trace_stall,
  output logic             ram_ren,
  output logic      [12:0] ram_raddr,
  input  wire logic [31:0] ram_rdata,
  output logic             ram_we,
  output logic      [12:0] ram_waddr,
  output logic      [31:0] ram_wdata
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  mtbpm_pkg::mtbpm_ptr_t   ptr, wm, ptr_next;
  mtbpm_pkg::mtbpm_state_t state;
  logic        wrap, en, halt, rpriv, wpriv, stopen, starten, autohalt, autostop, lock;
  logic [4:0]  mask;
  logic [30:0] last_pc;
  logic        reg_wr_q, ram_wr_q, user_q, ram_q, allow_q;
  logic [11:0] ofs_q;
  logic [12:0] raddr_q;
  logic [31:0] rdata_q;
  logic        ap, rsel, msel, allow, reg_wr_ok, wr_pos, wr_m, wr_flow, bus_wr;
  logic        pkt_valid, fifo_ready, out_valid, out_ready, adv, wrap_hit, wm_hit;
  logic [63:0] pkt, out_pkt;
  // Slot advance within the mask window; upper bits kept
  function automatic logic [12:0] mtbpm_adv(input logic [11:0] p, input logic [4:0] m);
    logic [4:0]  mm;
    logic [12:0] win;
    logic [11:0] inc;
    mm  = (m > `MTBPM_MASK_MAX) ? `MTBPM_MASK_MAX : m;
    win = (13'h0001 << (mm + 5'h01)) - 13'h0001;
    inc = p + 12'h001;
    return {(p & win[11:0]) == win[11:0], (p & ~win[11:0]) | (inc & win[11:0])};
  endfunction

  // ----------------------------------------
  // Bus slave, address phase capture
  // ----------------------------------------
  assign ap        = hready && htrans[1];
  assign rsel      = ap && hsel_reg;
  assign msel      = ap && hsel_ram;
  assign allow     = !(rpriv && !hprot[1]);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ram_ren   = msel && !hwrite && allow;
  assign ram_raddr = haddr[14:2];
  // Locked-out user reads see zero, not stale RAM data
  assign hrdata    = ram_q ? (allow_q ? ram_rdata : 32'h0000_0000) : rdata_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_wr_q <= `MTBPM_RST;
      ram_wr_q <= `MTBPM_RST;
      user_q   <= `MTBPM_RST;
      ram_q    <= `MTBPM_RST;
      allow_q  <= `MTBPM_RST;
      ofs_q    <= '0;
      raddr_q  <= '0;
    end else begin
      reg_wr_q <= rsel && hwrite;
      ram_wr_q <= msel && hwrite;
      user_q   <= !hprot[1];
      ram_q    <= msel;
      allow_q  <= allow;
      ofs_q    <= haddr[11:0];
      raddr_q  <= haddr[14:2];
    end
  end
  // Register read data sampled in the address phase
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= '0;
    end else if (rsel && !hwrite) begin
      case (haddr[11:0])
        `MTBPM_OFS_POS:    rdata_q <= {17'h00000, ptr, wrap, 2'b00};
        `MTBPM_OFS_MASTER: rdata_q <= {en, 21'h000000, halt, rpriv, wpriv, stopen, starten,
                                       mask};
        `MTBPM_OFS_FLOW:   rdata_q <= {17'h00000, wm, 1'b0, autohalt, autostop};
        `MTBPM_OFS_BASE:   rdata_q <= `MTBPM_BASE_VAL;
        default:           rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Register writes, data phase
  // ----------------------------------------
  assign reg_wr_ok = reg_wr_q && !(wpriv && user_q);
  assign wr_pos    = reg_wr_ok && ofs_q == `MTBPM_OFS_POS;
  assign wr_m      = reg_wr_ok && ofs_q == `MTBPM_OFS_MASTER;
  assign wr_flow   = reg_wr_ok && ofs_q == `MTBPM_OFS_FLOW;
  // Static master fields and flow register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rpriv    <= `MTBPM_RST;
      wpriv    <= `MTBPM_RST;
      stopen   <= `MTBPM_RST;
      starten  <= `MTBPM_RST;
      mask     <= '0;
      wm       <= '0;
      autohalt <= `MTBPM_RST;
      autostop <= `MTBPM_RST;
    end else begin
      if (wr_m) begin
        rpriv   <= hwdata[`MTBPM_M_RPRIV];
        wpriv   <= hwdata[`MTBPM_M_WPRIV];
        stopen  <= hwdata[`MTBPM_M_STOPEN];
        starten <= hwdata[`MTBPM_M_STARTEN];
        mask    <= hwdata[4:0];
      end
      if (wr_flow) begin
        wm       <= hwdata[14:3];
        autohalt <= hwdata[`MTBPM_F_AUTOHALT];
        autostop <= hwdata[`MTBPM_F_AUTOSTOP];
      end
    end
  end

  // ----------------------------------------
  // Pointer, wrap and watermark
  // ----------------------------------------
  assign {wrap_hit, ptr_next} = mtbpm_adv(ptr, mask);
  assign wm_hit = adv && ptr_next == wm;
  // Software write wins the pointer; hardware wrap set wins over clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ptr  <= '0;
      wrap <= `MTBPM_RST;
    end else begin
      if (wr_pos) ptr <= hwdata[14:3];
      else if (adv) ptr <= ptr_next;
      wrap <= (wr_pos ? hwdata[`MTBPM_POS_WRAP] : wrap) || (adv && wrap_hit);
    end
  end
  // Enable: stop events beat start events, both beat software
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      en   <= `MTBPM_RST;
      halt <= `MTBPM_RST;
      lock <= `MTBPM_RST;
    end else begin
      if ((stopen && trace_stop_input) || (wm_hit && autostop)) en <= 1'b0;
      else if (starten && trace_start_input && !lock) en <= 1'b1;
      else if (wr_m) en <= hwdata[`MTBPM_M_EN];
      halt <= (wr_m ? hwdata[`MTBPM_M_HALT] : halt) || (wm_hit && autohalt);
      if (wm_hit && autostop) lock <= 1'b1;
      else if ((wr_pos && hwdata[14:3] != ptr) || (wr_flow && hwdata[14:3] != wm)) begin
        lock <= 1'b0;
      end
    end
  end
  assign core_halt_request_out = halt && invasive_debug_enable;
  // ----------------------------------------
  // Packet capture from the trace bus
  // ----------------------------------------
  // A branch gives a source/destination pair
  assign pkt_valid   = en && iaexen && !iaeseq;
  assign pkt         = {iaex, 1'b0, last_pc, 1'b0};
  assign trace_stall = !fifo_ready;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) last_pc <= '0;
    else if (iaexen) last_pc <= iaex;
  end
  mtbpm_fifo #(
    .W (`MTBPM_PKT_W),
    .D (`MTBPM_FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .in_valid  (pkt_valid),
    .in_ready  (fifo_ready),
    .in_data   (pkt),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_pkt)
  );

  // ----------------------------------------
  // RAM write port: bus first, trace drains
  // ----------------------------------------
  assign bus_wr    = ram_wr_q && allow_q;
  assign out_ready = state == mtbpm_pkg::MTBPM_ST_SECOND && !bus_wr;
  assign adv       = out_valid && out_ready;
  // Packet leaves as two words; once started it always finishes
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= mtbpm_pkg::MTBPM_ST_FIRST;
    end else begin
      case (state)
        mtbpm_pkg::MTBPM_ST_FIRST: if (out_valid && !bus_wr) state <= mtbpm_pkg::MTBPM_ST_SECOND;
        mtbpm_pkg::MTBPM_ST_SECOND: if (!bus_wr) state <= mtbpm_pkg::MTBPM_ST_FIRST;
        default: state <= mtbpm_pkg::MTBPM_ST_FIRST;
      endcase
    end
  end
  // Trace words go out in slot order; a bus write borrows the port for a cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ram_we    <= `MTBPM_RST;
      ram_waddr <= '0;
      ram_wdata <= '0;
    end else begin
      ram_we    <= bus_wr || (out_valid && state == mtbpm_pkg::MTBPM_ST_FIRST) || out_ready;
      ram_waddr <= bus_wr ? raddr_q : {ptr, state};
      ram_wdata <= bus_wr ? hwdata : (out_ready ? out_pkt[63:32] : out_pkt[31:0]);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  ptr_step_a: assert property (adv && !wr_pos && !wrap_hit
                               |=> ptr == $past(ptr) + 12'h001)
    else $error("pointer did not advance by one slot");
  wrap_set_a: assert property (adv && wrap_hit |=> wrap)
    else $error("wrap flag not set on wrap");
  pos_zero_a: assert property (rsel && !hwrite && haddr[11:0] == `MTBPM_OFS_POS
                               |=> hrdata[31:15] == '0 && hrdata[1:0] == '0)
    else $error("position reserved bits not zero");
  master_zero_a: assert property (rsel && !hwrite && haddr[11:0] == `MTBPM_OFS_MASTER
                                  |=> hrdata[30:10] == '0)
    else $error("master reserved bits not zero");
  base_read_a: assert property (rsel && !hwrite && haddr[11:0] == `MTBPM_OFS_BASE
                                |=> hrdata == `MTBPM_BASE_VAL)
    else $error("base register value wrong");
  stop_in_a: assert property (stopen && trace_stop_input |=> !en)
    else $error("stop input did not clear enable");
  start_in_a: assert property (starten && trace_start_input && !lock && !stopen && !adv
                               |=> en)
    else $error("start input did not set enable");
  wm_stop_a: assert property (wm_hit && autostop |=> !en && lock)
    else $error("watermark did not stop trace");
  lock_hold_a: assert property (lock && !en && !reg_wr_q |=> !en)
    else $error("trace restarted while locked");
  halt_out_a: assert property (wm_hit && autohalt
                               |=> halt && core_halt_request_out == invasive_debug_enable)
    else $error("halt request not raised");
  ram_user_a: assert property (msel && !hwrite && rpriv && !hprot[1] |=> hrdata == '0)
    else $error("user RAM read not zero");
  wpriv_a: assert property (reg_wr_q && user_q && wpriv && ofs_q == `MTBPM_OFS_MASTER
                            |=> wpriv && rpriv == $past(rpriv) && mask == $past(mask))
    else $error("user write reached control register");
  pkt_done_a: assert property (state == mtbpm_pkg::MTBPM_ST_SECOND && !bus_wr
                               |=> ram_we && ram_waddr[0])
    else $error("packet second word not written");
  wrap_c:  cover property (adv && wrap_hit);
  wmhit_c: cover property (wm_hit && autostop);
  start_c: cover property (!en ##1 en && starten);
endmodule // mtbpm_top
`default_nettype wire

/* tb/mtbpm_ram_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Trace RAM model, synchronous read port
// ----------------------------------------
module mtbpm_ram_model (
  input  wire logic        core_clk,
  input  wire logic        ram_ren,
  input  wire logic [12:0] ram_raddr,
  output logic      [31:0] ram_rdata,
  input  wire logic        ram_we,
  input  wire logic [12:0] ram_waddr,
  input  wire logic [31:0] ram_wdata
);
  logic [31:0] mem [0:8191];
  initial ram_rdata = 32'h0000_0000;
  // Word store, one word per strobe
  always @(posedge core_clk) begin
    if (ram_we) mem[ram_waddr] <= ram_wdata;
  end
  // Data holds one cycle only; flipped after so a late sample cannot pass
  always @(posedge core_clk) begin
    if (ram_ren) ram_rdata <= mem[ram_raddr];
    else ram_rdata <= ~ram_rdata;
  end
endmodule // mtbpm_ram_model
`default_nettype wire

/* tb/mtbpm_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mtbpm_defines.svh"
module mtbpm_top_tb;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel_reg = 1'b0;
  logic        hsel_ram = 1'b0;
  logic        hwrite = 1'b0;
  logic        hready = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [3:0]  hprot = 4'h3;
  logic [30:0] iaex = 31'h0;
  logic        iaexen = 1'b0;
  logic        iaeseq = 1'b1;
  logic        trace_start_input = 1'b0;
  logic        trace_stop_input = 1'b0;
  logic        invasive_debug_enable = 1'b0;
  logic [31:0] hrdata, ram_rdata, ram_wdata, wd, d;
  logic [12:0] ram_raddr, ram_waddr;
  logic        hreadyout, hresp, core_halt_request_out, trace_stall, ram_ren, ram_we, wc;
  logic        dph = 1'b0;
  logic        stalled = 1'b0;
  logic [11:0] p;
  logic [31:0] rq [$];
  logic [31:0] wq_d [$];
  logic [12:0] wq_a [$];
  logic        wq_c [$];
  int          failures = 0;
  int          check_count = 0;
  int          seed = 27031;
  int          i;

  always #25 core_clk = ~core_clk;

  mtbpm_top i_mtbpm_top (.core_clk, .nrst, .hsel_reg, .hsel_ram, .haddr, .htrans, .hwrite,
    .hprot, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .iaex, .iaexen, .iaeseq,
    .trace_start_input, .trace_stop_input, .invasive_debug_enable, .core_halt_request_out,
    .trace_stall, .ram_ren, .ram_raddr, .ram_rdata, .ram_we, .ram_waddr, .ram_wdata);
  mtbpm_ram_model i_mtbpm_ram_model (.core_clk, .ram_ren, .ram_raddr, .ram_rdata, .ram_we,
    .ram_waddr, .ram_wdata);

  // ----------------------------------------
  // Comparison and closing
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Drivers: bus cycles, packets, start pulse
  // ----------------------------------------
  // One transfer, then an idle address phase while write data is held
  task automatic bus(input logic ram, input logic wr, input logic [31:0] a, input logic [31:0] dat,
                     input logic pv);
    @(posedge core_clk);
    #1;
    hsel_reg = !ram;
    hsel_ram = ram;
    haddr = a;
    htrans = 2'h2;
    hwrite = wr;
    hprot = {2'h0, pv, 1'b1};
    @(posedge core_clk);
    #1;
    hsel_reg = 1'b0;
    hsel_ram = 1'b0;
    htrans = 2'h0;
    hwdata = dat;
  endtask

  task automatic wreg(input logic [11:0] ofs, input logic [31:0] dat);
    bus(1'b0, 1'b1, {20'h0, ofs}, dat, 1'b1);
  endtask

  task automatic rd(input logic ram, input logic [31:0] a, input logic [31:0] exp,
                    input logic pv);
    rq.push_back(exp);
    bus(ram, 1'b0, a, 32'h0, pv);
  endtask

  task automatic note(input logic [12:0] a, input logic [31:0] dat, input logic c);
    wq_a.push_back(a);
    wq_d.push_back(dat);
    wq_c.push_back(c);
  endtask

  // Branch packet; source word content is our own format, so only its slot is checked
  task automatic pkt(input logic [11:0] ptr, input logic ex, input logic stop);
    @(posedge core_clk);
    #1;
    iaex = 31'($random(seed));
    iaexen = 1'b1;
    iaeseq = 1'b0;
    if (ex) begin
      note({ptr, 1'b0}, 32'h0, 1'b0);
      note({ptr, 1'b1}, {iaex, 1'b0}, 1'b1);
    end
    @(posedge core_clk);
    #1;
    iaexen = 1'b0;
    iaeseq = 1'b1;
    trace_stop_input = stop;
    @(posedge core_clk);
    #1;
    trace_stop_input = 1'b0;
  endtask

  task automatic start_pulse;
    @(posedge core_clk);
    #1;
    trace_start_input = 1'b1;
    @(posedge core_clk);
    #1;
    trace_start_input = 1'b0;
  endtask

  // Bounded wait for all noted RAM writes to appear
  task automatic drain;
    for (int k = 0; k < 100 && wq_a.size() != 0; k++) @(posedge core_clk);
    if (wq_a.size() != 0) begin
      failures++;
      end_of_test;
    end else begin
      repeat (2) @(posedge core_clk);
    end
  endtask

  // ----------------------------------------
  // Monitor: read data and RAM writes against notes
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (dph) begin
      chk(hrdata, rq.pop_front());
      chk({30'h0, hreadyout, hresp}, 32'h0000_0002);
    end
    if (ram_we && wq_a.size() == 0) begin
      chk({19'h0, ram_waddr}, 32'hFFFF_FFFF);
    end else if (ram_we) begin
      wd = wq_d.pop_front();
      wc = wq_c.pop_front();
      chk({19'h0, ram_waddr}, {19'h0, wq_a.pop_front()});
      if (wc) chk(ram_wdata, wd);
    end
    dph <= (hsel_reg | hsel_ram) & htrans[1] & hready & !hwrite;
  end

  initial begin
    #3000000;
    failures++;
    end_of_test;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    // Reset values, base, unmapped place
    rd(1'b0, {20'h0, `MTBPM_OFS_POS}, 32'h0, 1'b1);
    rd(1'b0, {20'h0, `MTBPM_OFS_MASTER}, 32'h0, 1'b1);
    rd(1'b0, {20'h0, `MTBPM_OFS_FLOW}, 32'h0, 1'b1);
    rd(1'b0, {20'h0, `MTBPM_OFS_BASE}, `MTBPM_BASE_VAL, 1'b1);
    rd(1'b0, 32'h0000_0010, 32'h0, 1'b1);
    // Unimplemented and reserved bits
    wreg(`MTBPM_OFS_POS, 32'hFFFF_FFFB);
    rd(1'b0, {20'h0, `MTBPM_OFS_POS}, 32'h0000_7FF8, 1'b1);
    wreg(`MTBPM_OFS_MASTER, 32'h7FFF_FC0A);
    rd(1'b0, {20'h0, `MTBPM_OFS_MASTER}, 32'h0000_000A, 1'b1);
    // Buffer at base, position and flow set before enabling
    wreg(`MTBPM_OFS_POS, `MTBPM_BASE_VAL & 32'h0000_7FF8);
    wreg(`MTBPM_OFS_FLOW, 32'h0);
    wreg(`MTBPM_OFS_MASTER, 32'h8000_000B);
    pkt(12'hE00, 1'b1, 1'b0);
    drain();
    rd(1'b0, {20'h0, `MTBPM_OFS_POS}, 32'h0000_7008, 1'b1);
    // Agent view of the slot: upper position bits pick the low RAM window
    rd(1'b1, 32'h1FFF_8004 + (`MTBPM_BASE_VAL & 32'h0000_7FF8), {iaex, 1'b0}, 1'b1);
    // Burst for 24 cycles, past the point where the packet FIFO refuses, then drain
    p = 12'hE01;
    for (i = 0; i < 24; i++) begin
      @(posedge core_clk);
      #1;
      iaex = 31'($random(seed));
      iaexen = 1'b1;
      iaeseq = 1'b0;
      if (!trace_stall) begin
        note({p, 1'b0}, 32'h0, 1'b0);
        note({p, 1'b1}, {iaex, 1'b0}, 1'b1);
        p++;
      end else begin
        stalled = 1'b1;
      end
    end
    @(posedge core_clk);
    #1;
    iaexen = 1'b0;
    iaeseq = 1'b1;
    drain();
    chk({31'h0, stalled}, 32'h1);
    rd(1'b0, {20'h0, `MTBPM_OFS_POS}, {17'h0, p, 3'h0}, 1'b1);
    // Stop input while a packet is in flight
    wreg(`MTBPM_OFS_MASTER, 32'h8000_004B);
    pkt(p, 1'b1, 1'b1);
    drain();
    rd(1'b0, {20'h0, `MTBPM_OFS_MASTER}, 32'h0000_004B, 1'b1);
    pkt(p + 12'h1, 1'b0, 1'b0);
    drain();
    // Watermark stop and halt, start lock, release by pointer write
    wreg(`MTBPM_OFS_POS, 32'h0000_0200);
    wreg(`MTBPM_OFS_FLOW, 32'h0000_020B);
    rd(1'b0, {20'h0, `MTBPM_OFS_FLOW}, 32'h0000_020B, 1'b1);
    wreg(`MTBPM_OFS_MASTER, 32'h8000_002B);
    pkt(12'h040, 1'b1, 1'b0);
    drain();
    rd(1'b0, {20'h0, `MTBPM_OFS_MASTER}, 32'h0000_022B, 1'b1);
    chk({31'h0, core_halt_request_out}, 32'h0);
    invasive_debug_enable = 1'b1;
    @(posedge core_clk);
    #1;
    chk({31'h0, core_halt_request_out}, 32'h1);
    start_pulse();
    rd(1'b0, {20'h0, `MTBPM_OFS_MASTER}, 32'h0000_022B, 1'b1);
    wreg(`MTBPM_OFS_POS, 32'h0000_0200);
    start_pulse();
    rd(1'b0, {20'h0, `MTBPM_OFS_MASTER}, 32'h8000_022B, 1'b1);
    wreg(`MTBPM_OFS_MASTER, 32'h0000_000B);
    @(posedge core_clk);
    #1;
    chk({31'h0, core_halt_request_out}, 32'h0);
    // Smallest circular buffer wraps after one packet
    wreg(`MTBPM_OFS_FLOW, 32'h0);
    wreg(`MTBPM_OFS_POS, 32'h0000_0108);
    wreg(`MTBPM_OFS_MASTER, 32'h8000_0000);
    pkt(12'h021, 1'b1, 1'b0);
    drain();
    rd(1'b0, {20'h0, `MTBPM_OFS_POS}, 32'h0000_0104, 1'b1);
    // Position set back to RAM start reads slot zero
    wreg(`MTBPM_OFS_POS, 32'h0);
    rd(1'b0, {20'h0, `MTBPM_OFS_POS}, 32'h0, 1'b1);
    // Privilege of control writes and of RAM accesses
    wreg(`MTBPM_OFS_MASTER, 32'h0000_0180);
    bus(1'b0, 1'b1, {20'h0, `MTBPM_OFS_MASTER}, 32'h0, 1'b0);
    rd(1'b0, {20'h0, `MTBPM_OFS_MASTER}, 32'h0000_0180, 1'b0);
    d = $random(seed);
    note(13'h0010, d, 1'b1);
    bus(1'b1, 1'b1, 32'h2000_0040, d, 1'b1);
    bus(1'b1, 1'b1, 32'h2000_0040, ~d, 1'b0);
    drain();
    rd(1'b1, 32'h2000_0040, 32'h0, 1'b0);
    rd(1'b1, 32'h2000_0040, d, 1'b1);
    wreg(`MTBPM_OFS_MASTER, 32'h0);
    rd(1'b1, 32'h2000_0040, d, 1'b0);
    drain();
    end_of_test;
  end
endmodule // mtbpm_top_tb
`default_nettype wire
